// *** design/slow_clock_divider.sv ***
// Odd-factor divider turning slow-oscillator ticks into count enables.
module slow_clock_divider (
  // Clock, reset and freeze.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // One pulse per slow-oscillator cycle.
  input wire logic i_slow_tick,
  // Divisor select, code k divides by 2k+1.
  input wire logic [2:0] i_select,
  // One pulse per divided watchdog clock cycle.
  output logic o_count_enable
);

  typedef struct packed {
    logic [3:0] count;
    logic pulse;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;
  logic [3:0] last;

  // -------------------------------------------------------------------
  // Modulo-N counter
  // -------------------------------------------------------------------
  // The terminal value is N-1 = 2k, so a select change takes effect at
  // once; a count already past the new end wraps on the next tick.
  always_comb begin
    last = {i_select, 1'b0}; // R01
    next_s = s;
    next_s.pulse = 1'b0;
    if (i_slow_tick) begin
      if (s.count >= last) begin // R10
        next_s.count = 4'h0;
        next_s.pulse = 1'b1; // R05
      end else begin
        next_s.count = s.count + 4'h1;
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_count_enable = s.pulse;

endmodule

// *** design/watchdog_timer.sv ***
// Watchdog timing core with AHB-Lite registers and interrupt.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.

// Functional notes
// R01: Counting clock is slow oscillator divided by 1,3,5..15 per select.
// R02: Time-out select gives 2048 divided cycles, doubling per code to 1M.
// R03: First expiry is early warning; second equal period is final time-out.
// R04: Software never programs time-out select codes 1010 to 1111.
// R05: Divider select 001 advances the counter once per three ticks.
// R06: First expiry sets early-warning flag when its enable is set.
// R07: Second expiry sets time-out flag when interrupt operation is on.
// R08: Unlock bit clears itself four cycles after being written one.
// R09: Divider select MSB sits at bit 4, low bits at 1:0.
// R10: Divider is a modulo-N counter pulsing the counter every N ticks.
module watchdog_timer
  import wdt_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Slow oscillator, one pulse per 128 kHz cycle.
  input wire logic i_slow_tick,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Results.
  output logic o_irq,
  output logic o_system_reset
);

  typedef struct packed {
    logic timeout_irq_enable;
    logic system_reset_enable;
    logic [3:0] timeout_length_select;
    logic [2:0] slow_clock_divisor_select;
    logic early_warning_irq_enable;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic [2:0] unlock_count;
    logic [20:0] count;
    phase_t phase;
    logic sys_reset;
    logic pend_write;
    logic [7:0] pend_addr;
    logic [31:0] rdata;
  } wdt_state_t;

  wdt_state_t s;
  wdt_state_t next_s;
  logic count_enable;
  logic unlocked;
  logic running;
  logic restart;
  logic addr_phase;
  logic [3:0] tsel_eff;
  logic [20:0] limit;
  logic [7:0] wbyte;
  logic [EVT_W-1:0] clear;
  logic [EVT_W-1:0] set;

  // -------------------------------------------------------------------
  // Divider
  // -------------------------------------------------------------------
  slow_clock_divider u_divider (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_slow_tick(i_slow_tick),
    .i_select(s.slow_clock_divisor_select),
    .o_count_enable(count_enable)
  );

  // -------------------------------------------------------------------
  // Register read view
  // -------------------------------------------------------------------
  // Reads sample state at the address phase, so a write still in its
  // data phase is not yet visible to a read issued right behind it.
  function automatic logic [7:0] read_view(wdt_state_t st, logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_CTRL: begin
        v[CTRL_TIMEOUT_FLAG] = st.status[EVT_TIMEOUT];
        v[CTRL_TIMEOUT_IE] = st.timeout_irq_enable;
        v[CTRL_TSEL_MSB] = st.timeout_length_select[3];
        v[CTRL_UNLOCK] = (st.unlock_count != 3'h0);
        v[CTRL_RESET_EN] = st.system_reset_enable;
        v[2:0] = st.timeout_length_select[2:0];
      end
      OFS_DIV: begin
        v[DIV_SEL_MSB] = st.slow_clock_divisor_select[2]; // R09
        v[DIV_EW_FLAG] = st.status[EVT_EARLY];
        v[DIV_EW_IE] = st.early_warning_irq_enable;
        v[1:0] = st.slow_clock_divisor_select[1:0]; // R09
      end
      OFS_STATUS: v[EVT_W-1:0] = st.status;
      OFS_MASK: v[EVT_W-1:0] = st.mask;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sys_reset = 1'b0;
    clear = '0;
    set = '0;
    restart = 1'b0;
    wbyte = i_hwdata[7:0];
    unlocked = (s.unlock_count != 3'h0);
    running = s.timeout_irq_enable | s.system_reset_enable;
    // Reserved select codes are held to the longest defined length.
    tsel_eff = (s.timeout_length_select > TSEL_MAX) ?
               TSEL_MAX : s.timeout_length_select;
    limit = BASE_COUNT << tsel_eff; // R02

    // Unlock window counts down to closed.
    if (unlocked) begin
      next_s.unlock_count = s.unlock_count - 3'h1; // R08
    end

    // Data phase of a write; the address was captured one cycle before.
    if (s.pend_write) begin
      case (s.pend_addr)
        OFS_CTRL: begin
          next_s.timeout_irq_enable = wbyte[CTRL_TIMEOUT_IE];
          // Length changes and reset-enable clears need the window.
          if (unlocked) begin
            next_s.timeout_length_select =
              {wbyte[CTRL_TSEL_MSB], wbyte[2:0]};
          end
          if (wbyte[CTRL_RESET_EN] || unlocked) begin
            next_s.system_reset_enable = wbyte[CTRL_RESET_EN];
          end
          if (wbyte[CTRL_UNLOCK]) begin
            next_s.unlock_count = UNLOCK_CYCLES; // R08
          end
          clear[EVT_TIMEOUT] = wbyte[CTRL_TIMEOUT_FLAG];
        end
        OFS_DIV: begin
          next_s.slow_clock_divisor_select =
            {wbyte[DIV_SEL_MSB], wbyte[1:0]}; // R09
          next_s.early_warning_irq_enable = wbyte[DIV_EW_IE];
          clear[EVT_EARLY] = wbyte[DIV_EW_FLAG];
        end
        OFS_RESTART: restart = 1'b1;
        OFS_STATUS: clear = wbyte[EVT_W-1:0];
        OFS_MASK: next_s.mask = wbyte[EVT_W-1:0];
        default: ;
      endcase
    end

    // Time-out counter, paced by the divider pulse.
    if (!running || restart) begin
      next_s.count = 21'h0;
      next_s.phase = PHASE_EARLY;
    end else if (count_enable) begin
      if (s.count == limit - 21'h1) begin
        next_s.count = 21'h0;
        case (s.phase)
          PHASE_EARLY: begin
            next_s.phase = PHASE_FINAL; // R03
            set[EVT_EARLY] = s.early_warning_irq_enable; // R06
          end
          PHASE_FINAL: begin
            next_s.phase = PHASE_EARLY;
            if (s.timeout_irq_enable) begin
              set[EVT_TIMEOUT] = 1'b1; // R07
              // With reset also on, the interrupt is spent and the next
              // double time-out resets the system.
              if (s.system_reset_enable) begin
                next_s.timeout_irq_enable = 1'b0;
              end
            end else if (s.system_reset_enable) begin
              next_s.sys_reset = 1'b1; // R03
              set[EVT_RESET] = 1'b1;
            end
          end
          default: next_s.phase = PHASE_EARLY;
        endcase
      end else begin
        next_s.count = s.count + 21'h1;
      end
    end

    // A hardware set in the same cycle as a clear wins.
    next_s.status = (s.status & ~clear) | set;

    // Address phase capture.
    addr_phase = i_hsel && i_htrans[1] && i_hready;
    next_s.pend_write = addr_phase && i_hwrite;
    next_s.pend_addr = i_haddr[7:0];
    if (addr_phase && !i_hwrite) begin
      next_s.rdata = {24'h000000, read_view(s, i_haddr[7:0])};
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s <= '0;
      s.timeout_length_select <= TSEL_RESET;
      s.slow_clock_divisor_select <= DIV_SEL_RESET;
      s.mask <= MASK_RESET;
      s.phase <= PHASE_EARLY;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  // Zero-wait slave: every transfer completes with OKAY.
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = s.rdata;
  assign o_irq = |(s.status & s.mask);
  assign o_system_reset = s.sys_reset;

endmodule

// *** design/wdt_pkg.sv ***
// Shared constants and types of the watchdog timing core.
package wdt_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_RESTART = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  // Main control register.
  localparam int CTRL_TIMEOUT_FLAG = 7;
  localparam int CTRL_TIMEOUT_IE = 6;
  localparam int CTRL_TSEL_MSB = 5;
  localparam int CTRL_UNLOCK = 4;
  localparam int CTRL_RESET_EN = 3;
  // Divider control register.
  localparam int DIV_SEL_MSB = 4;
  localparam int DIV_EW_FLAG = 3;
  localparam int DIV_EW_IE = 2;
  // Sticky event bits in status and mask registers.
  localparam int EVT_EARLY = 0;
  localparam int EVT_TIMEOUT = 1;
  localparam int EVT_RESET = 2;
  localparam int EVT_W = 3;

  // ---------------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------------
  localparam logic [3:0] TSEL_RESET = 4'h0;
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
  // The unlock bit drops by itself this many cycles after being set.
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Shortest time-out in divided cycles; each select step doubles it.
  localparam logic [20:0] BASE_COUNT = 21'h000800;
  // Highest defined time-out select code.
  localparam logic [3:0] TSEL_MAX = 4'h9;

  // Which half of the double time-out interval is running.
  typedef enum logic {
    PHASE_EARLY,
    PHASE_FINAL
  } phase_t;

endpackage

// *** sim/tb_watchdog_timer.sv ***
// Self-checking testbench for the watchdog timing core.
module tb_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  logic i_clock, i_reset, i_clk_en, i_slow_tick, i_hsel, i_hwrite;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, v;
  logic [1:0] i_htrans;
  logic o_hreadyout, o_hresp, o_irq, o_system_reset;
  int mismatches, tests_run, pulses;
  logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14};
  // The slave's own ready closes the loop, as on a one-slave bus.
  watchdog_timer u_watchdog_timer (.i_clock(i_clock), .i_reset(i_reset),
    .i_clk_en(i_clk_en), .i_slow_tick(i_slow_tick), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_irq(o_irq), .o_system_reset(o_system_reset));
  // ---------------------------------------------------------------------
  // Clock and pulse monitor
  // ---------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Counting pulses catches one that is early even if it is brief.
  always @(posedge i_clock) begin
    if (o_system_reset === 1'b1) pulses++;
  end
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready; a stuck bus ends the run.
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    if (o_hreadyout !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: bus ready timeout", $time);
      end_of_test();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'b10;
    i_hwrite <= w;
    wait_rdy();
    i_htrans <= 2'b00;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    wait_rdy();
    q = o_hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask
  // One slow tick every three clocks, so a count of n is exact.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clock) i_slow_tick <= 1'b1;
      @(posedge i_clock) i_slow_tick <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task automatic do_reset();
    @(posedge i_clock) i_reset <= 1'b1;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {i_reset, i_clk_en, i_slow_tick, i_hsel, i_hwrite} = 5'b11000;
    {i_haddr, i_hwdata, i_htrans} = '0;
    do_reset();
    foreach (offs[i]) rdc(offs[i], 32'h0);
    wr(8'h14, 32'hff);
    rdc(8'h14, 32'h0);
    // Length select is refused outside the unlock window.
    wr(OFS_CTRL, 32'h01);
    rdc(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h10);
    rdc(OFS_CTRL, 32'h10);
    repeat (6) @(posedge i_clock);
    rdc(OFS_CTRL, 32'h0);
    for (int k = 0; k < 8; k++) begin
      v = {27'h0, k[2], 2'b00, k[1:0]};
      wr(OFS_DIV, v);
      rdc(OFS_DIV, v);
    end
    // Interrupt mode, shortest length, early warning masked off.
    wr(OFS_DIV, 32'h4);
    wr(OFS_MASK, 32'h2);
    wr(OFS_CTRL, 32'h40);
    // A restart part-way through must push the early warning back.
    ticks(1000);
    wr(OFS_RESTART, 32'h0);
    ticks(2047);
    rdc(OFS_DIV, 32'h4);
    ticks(1);
    rdc(OFS_DIV, 32'hc);
    check(32'(o_irq), 32'h0);
    ticks(2047);
    rdc(OFS_CTRL, 32'h40);
    ticks(1);
    rdc(OFS_CTRL, 32'hc0);
    check(32'(o_irq), 32'h1);
    rdc(OFS_STATUS, 32'h3);
    wr(OFS_STATUS, 32'h2);
    // The clear lands on the edge that ends the write, so look one later.
    @(posedge i_clock);
    check(32'(o_irq), 32'h0);
    rdc(OFS_STATUS, 32'h1);
    // The early-warning flag also clears by a one in the divider register.
    wr(OFS_DIV, 32'hc);
    rdc(OFS_STATUS, 32'h0);
    // A doubled length needs the unlock first.
    do_reset();
    wr(OFS_CTRL, 32'h10);
    wr(OFS_CTRL, 32'h41);
    rdc(OFS_CTRL, 32'h41);
    wr(OFS_DIV, 32'h4);
    ticks(4095);
    rdc(OFS_DIV, 32'h4);
    ticks(1);
    rdc(OFS_DIV, 32'hc);
    // Divide by three stretches the early warning threefold.
    do_reset();
    wr(OFS_DIV, 32'h5);
    wr(OFS_CTRL, 32'h40);
    ticks(6143);
    rdc(OFS_DIV, 32'h5);
    ticks(1);
    rdc(OFS_DIV, 32'hd);
    // Reset mode; ticks seen while frozen must not count.
    do_reset();
    pulses = 0;
    wr(OFS_CTRL, 32'h08);
    ticks(4094);
    @(posedge i_clock) i_clk_en <= 1'b0;
    ticks(3);
    @(posedge i_clock) i_clk_en <= 1'b1;
    ticks(1);
    check(pulses, 0);
    ticks(1);
    repeat (3) @(posedge i_clock);
    check(pulses, 1);
    end_of_test();
  end
endmodule

// *** sim/watchdog_timer_props.sv ***
// Port-level checker for the watchdog timing core.
module watchdog_timer_props (
  // Clock, reset, freeze and slow tick.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_slow_tick,
  // Bus and results.
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_irq,
  input wire logic o_system_reset
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ---------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------
  logic rd_q;
  logic wr_q;
  logic [3:0] tick_age;
  // Taken phases and the age of the last tick, saturating so it never wraps.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      tick_age <= 4'hf;
    end else begin
      rd_q <= i_hsel & i_htrans[1] & i_hready & i_clk_en & !i_hwrite;
      wr_q <= i_hsel & i_htrans[1] & i_hready & i_clk_en & i_hwrite;
      tick_age <= i_slow_tick ? 4'h0 : tick_age + {3'h0, tick_age != 4'hf};
    end
  end
  // A reset pulse is followed by a long quiet stretch.
  sequence quiet_run;
    !o_system_reset [*8];
  endsequence
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  chk_resp_okay: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
    else $error("bus response not OKAY with zero wait");
  chk_rdata_upper: assert property (o_hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_rdata_hold: assert property (!rd_q |-> $stable(o_hrdata))
    else $error("read data moved without a read");
  chk_irq_fall: assert property ($fell(o_irq) |-> $past(wr_q))
    else $error("interrupt dropped without a write");
  chk_irq_cause: assert property (
    $rose(o_irq) |-> $past(wr_q) || tick_age < 4'h8)
    else $error("interrupt rose with no tick or write");
  chk_pulse_single: assert property (o_system_reset |=> quiet_run)
    else $error("system reset not a single pulse");
  chk_frozen_state: assert property (
    !i_clk_en |=> $stable(o_irq) && $stable(o_hrdata))
    else $error("outputs moved while frozen");
  chk_release_quiet: assert property ($fell(i_reset) |->
    !o_irq && !o_system_reset && o_hrdata == 32'h0)
    else $error("outputs not idle after reset");
endmodule
bind watchdog_timer watchdog_timer_props u_watchdog_timer_props (
  .i_clock(i_clock), .i_reset(i_reset), .i_clk_en(i_clk_en),
  .i_slow_tick(i_slow_tick), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq),
  .o_system_reset(o_system_reset));
